// ---- hw/ebtcf_pkg.sv ----
/*
 Constants for the 8-bit timer control and flag block: register offsets,
 field positions, reset values, clock select codes and prescaler ratios.
 Assumes a 32-bit Avalon-MM slave with word-aligned registers.
*/
package ebtcf_pkg;
   localparam logic [4:0] EBTCF_OFS_CTRL_A = 5'h00;
   localparam logic [4:0] EBTCF_OFS_CTRL_B = 5'h04;
   localparam logic [4:0] EBTCF_OFS_COUNT = 5'h08;
   localparam logic [4:0] EBTCF_OFS_CMP_A = 5'h0c;
   localparam logic [4:0] EBTCF_OFS_CMP_B = 5'h10;
   localparam logic [4:0] EBTCF_OFS_MASK = 5'h14;
   localparam logic [4:0] EBTCF_OFS_FLAGS = 5'h18;
   localparam logic [4:0] EBTCF_OFS_ACK = 5'h1c;
   localparam int EBTCF_ADDR_W = 5;

   // Control A layout: output actions and low mode bits
   localparam int EBTCF_CA_ACT_A = 6;
   localparam int EBTCF_CA_ACT_B = 4;
   localparam int EBTCF_CA_WGM_LO = 0;
   localparam logic [7:0] EBTCF_CA_MASK = 8'hf3;
   // Control B layout
   localparam int EBTCF_CB_FORCE_A = 7;
   localparam int EBTCF_CB_FORCE_B = 6;
   localparam int EBTCF_CB_WGM_TOP = 3;
   localparam int EBTCF_CB_CS = 0;
   localparam logic [7:0] EBTCF_CB_READ_MASK = 8'h0f;
   // Flag and mask bit positions
   localparam int EBTCF_BIT_MATCH_B = 2;
   localparam int EBTCF_BIT_MATCH_A = 1;
   localparam int EBTCF_BIT_OVF = 0;
   localparam logic [7:0] EBTCF_FLAG_MASK = 8'h07;

   localparam logic [7:0] EBTCF_RESET_BYTE = 8'h00;
   localparam logic [7:0] EBTCF_MAX = 8'hff;
   localparam logic [7:0] EBTCF_BOTTOM = 8'h00;

   localparam logic [2:0] EBTCF_CS_STOP = 3'h0;
   localparam logic [2:0] EBTCF_CS_DIV1 = 3'h1;
   localparam logic [2:0] EBTCF_CS_DIV8 = 3'h2;
   localparam logic [2:0] EBTCF_CS_DIV64 = 3'h3;
   localparam logic [2:0] EBTCF_CS_DIV256 = 3'h4;
   localparam logic [2:0] EBTCF_CS_DIV1024 = 3'h5;
   localparam logic [2:0] EBTCF_CS_EXT_FALL = 3'h6;
   localparam logic [2:0] EBTCF_CS_EXT_RISE = 3'h7;
   localparam int EBTCF_PRE_W = 10;
   localparam logic [9:0] EBTCF_DIV8_M = 10'h007;
   localparam logic [9:0] EBTCF_DIV64_M = 10'h03f;
   localparam logic [9:0] EBTCF_DIV256_M = 10'h0ff;
   localparam logic [9:0] EBTCF_DIV1024_M = 10'h3ff;

   // Waveform modes (3 bits: top bit from control B)
   localparam logic [2:0] EBTCF_WGM_NORMAL = 3'h0;
   localparam logic [2:0] EBTCF_WGM_PC_FF = 3'h1;
   localparam logic [2:0] EBTCF_WGM_CTC = 3'h2;
   localparam logic [2:0] EBTCF_WGM_FAST_FF = 3'h3;
   localparam logic [2:0] EBTCF_WGM_PC_CMP = 3'h5;
   localparam logic [2:0] EBTCF_WGM_FAST_CMP = 3'h7;

   localparam logic [1:0] EBTCF_ACT_NONE = 2'h0;
   localparam logic [1:0] EBTCF_ACT_TOGGLE = 2'h1;
   localparam logic [1:0] EBTCF_ACT_CLEAR = 2'h2;
   localparam logic [1:0] EBTCF_ACT_SET = 2'h3;
endpackage

// ---- hw/ebtcf_prescaler.sv ----
/*
 Clock select unit: prescaler divider and external pin edge detector that
 produce the one-cycle timer tick.
 Assumes the external pin is already synchronous to the system clock.
*/
`timescale 1ns/1ps
module ebtcf_prescaler (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic [2:0] i_clock_source_select,
   input wire logic i_ext_count_pin,
   output logic o_tick
);
   import ebtcf_pkg::*;

   logic [EBTCF_PRE_W-1:0] div_q;
   logic ext_q;
   logic tick_d;

   // Free-running divider shared by all divided rates
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end

   // Pin is sampled regardless of its direction
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         ext_q <= 1'b0;
      end else begin
         ext_q <= i_ext_count_pin;
      end
   end

   always_comb begin
      tick_d = 1'b0;
      case (i_clock_source_select)
         EBTCF_CS_STOP: tick_d = 1'b0;
         EBTCF_CS_DIV1: tick_d = 1'b1;
         EBTCF_CS_DIV8: tick_d = (div_q & EBTCF_DIV8_M) == EBTCF_DIV8_M;
         EBTCF_CS_DIV64: tick_d = (div_q & EBTCF_DIV64_M) == EBTCF_DIV64_M;
         EBTCF_CS_DIV256: tick_d = (div_q & EBTCF_DIV256_M) == EBTCF_DIV256_M;
         EBTCF_CS_DIV1024: tick_d = div_q == EBTCF_DIV1024_M;
         EBTCF_CS_EXT_FALL: tick_d = ext_q & ~i_ext_count_pin;
         EBTCF_CS_EXT_RISE: tick_d = ~ext_q & i_ext_count_pin;
         default: tick_d = 1'b0;
      endcase
   end

   assign o_tick = tick_d;
endmodule

// ---- hw/ebtcf_timer.sv ----
/*
 8-bit timer/counter: control, counter, compare, mask and flag registers,
 waveform outputs and interrupt requests, with an Avalon-MM register slave.
 Assumes a single 200 MHz clock, synchronous active-low reset and an
 external count pin synchronous to that clock.
*/
// Behaviour
// - Force strobes act only in non-PWM modes
// - Force strobe applies match to output now
// - Forced match sets no flag, no clear
// - Force bits always read back zero
// - Clock select: stop, 1, 8, 64, 256, 1024
// - Codes 110/111 count external falling/rising edges
// - External pin counts even when output
// - Counter is software readable and writable
// - Counter write blocks next tick's match
// - Two compare registers matched against counter
// - Interrupt needs mask, global enable and flag
// - Reserved bits read as zero
// - Matches set compare flags B and A
// - Flags clear on vector or written one
// - Overflow flag set per waveform mode
// - Control B bit 3 is top mode bit
`timescale 1ns/1ps
module ebtcf_timer (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic [ebtcf_pkg::EBTCF_ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_ext_count_pin,
   input wire logic i_cpu_status_word_ie,
   output logic o_wave_out_a,
   output logic o_wave_out_b,
   output logic [2:0] o_irq_req
);
   import ebtcf_pkg::*;

   logic [7:0] ctrl_a_q;
   logic [7:0] ctrl_b_q;
   logic [7:0] count_q;
   logic [7:0] cmp_a_q;
   logic [7:0] cmp_b_q;
   logic [7:0] cmp_a_buf_q;
   logic [7:0] cmp_b_buf_q;
   logic [2:0] mask_q;
   logic [2:0] flags_q;
   logic down_q;
   logic block_q;
   logic wave_a_q;
   logic wave_b_q;
   logic [2:0] irq_q;
   logic [31:0] rdata_q;
   logic ack_q;
   logic wait_q;
   logic tick;

   logic [2:0] wgm;
   logic pwm_mode;
   logic fast_mode;
   logic pc_mode;
   logic [7:0] top_val;
   logic acc;
   logic wr_en;
   logic rd_en;
   logic [7:0] wbyte;
   logic match_a;
   logic match_b;
   logic at_top;
   logic at_bottom;
   logic ovf_evt;
   logic [2:0] set_evt;
   logic [2:0] clr_w;
   logic force_a;
   logic force_b;
   logic [7:0] rd_mux;

   ebtcf_prescaler u_pre (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_clock_source_select(ctrl_b_q[EBTCF_CB_CS +: 3]),
      .i_ext_count_pin(i_ext_count_pin),
      .o_tick(tick)
   );

   // Mode decode
   assign wgm = {ctrl_b_q[EBTCF_CB_WGM_TOP], ctrl_a_q[EBTCF_CA_WGM_LO +: 2]};
   assign fast_mode = (wgm == EBTCF_WGM_FAST_FF) || (wgm == EBTCF_WGM_FAST_CMP);
   assign pc_mode = (wgm == EBTCF_WGM_PC_FF) || (wgm == EBTCF_WGM_PC_CMP);
   assign pwm_mode = fast_mode || pc_mode;
   assign top_val = ((wgm == EBTCF_WGM_CTC) || (wgm == EBTCF_WGM_PC_CMP) ||
                     (wgm == EBTCF_WGM_FAST_CMP)) ? cmp_a_q : EBTCF_MAX;

   // Bus access: one cycle of waitrequest, answer on the second cycle
   assign acc = (i_avs_read || i_avs_write) && !ack_q;
   assign wr_en = i_avs_write && !ack_q;
   assign rd_en = i_avs_read && !ack_q;
   assign wbyte = i_avs_writedata[7:0];

   function automatic logic wr_hit(input logic [4:0] ofs);
      wr_hit = wr_en && (i_avs_address == ofs) && i_avs_byteenable[0];
   endfunction

   // Compare values seen by the comparators: live in non-PWM, buffered in PWM
   assign match_a = tick && !block_q && (count_q == (pwm_mode ? cmp_a_buf_q : cmp_a_q));
   assign match_b = tick && !block_q && (count_q == (pwm_mode ? cmp_b_buf_q : cmp_b_q));
   assign at_top = count_q == top_val;
   assign at_bottom = count_q == EBTCF_BOTTOM;

   always_comb begin
      ovf_evt = 1'b0;
      if (tick) begin
         case (wgm)
            EBTCF_WGM_NORMAL, EBTCF_WGM_CTC, EBTCF_WGM_FAST_FF: ovf_evt = count_q == EBTCF_MAX;
            EBTCF_WGM_PC_FF, EBTCF_WGM_PC_CMP: ovf_evt = at_bottom && down_q;
            EBTCF_WGM_FAST_CMP: ovf_evt = at_top;
            default: ovf_evt = 1'b0;
         endcase
      end
   end

   // Force strobes only in non-PWM modes, never touching flags or counter
   assign force_a = wr_hit(EBTCF_OFS_CTRL_B) && wbyte[EBTCF_CB_FORCE_A] && !pwm_mode;
   assign force_b = wr_hit(EBTCF_OFS_CTRL_B) && wbyte[EBTCF_CB_FORCE_B] && !pwm_mode;

   assign set_evt = {match_b, match_a, ovf_evt};
   assign clr_w = wr_hit(EBTCF_OFS_FLAGS) ? wbyte[2:0] : 3'h0;

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         ctrl_a_q <= EBTCF_RESET_BYTE;
         ctrl_b_q <= EBTCF_RESET_BYTE;
         cmp_a_q <= EBTCF_RESET_BYTE;
         cmp_b_q <= EBTCF_RESET_BYTE;
         mask_q <= 3'h0;
      end else begin
         if (wr_hit(EBTCF_OFS_CTRL_A)) begin
            ctrl_a_q <= wbyte & EBTCF_CA_MASK;
         end
         if (wr_hit(EBTCF_OFS_CTRL_B)) begin
            ctrl_b_q <= wbyte & EBTCF_CB_READ_MASK;
         end
         if (wr_hit(EBTCF_OFS_CMP_A)) begin
            cmp_a_q <= wbyte;
         end
         if (wr_hit(EBTCF_OFS_CMP_B)) begin
            cmp_b_q <= wbyte;
         end
         if (wr_hit(EBTCF_OFS_MASK)) begin
            mask_q <= wbyte[2:0];
         end
      end
   end

   // PWM compare buffers reload at top
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         cmp_a_buf_q <= EBTCF_RESET_BYTE;
         cmp_b_buf_q <= EBTCF_RESET_BYTE;
      end else if (!pwm_mode || (tick && at_top)) begin
         cmp_a_buf_q <= cmp_a_q;
         cmp_b_buf_q <= cmp_b_q;
      end
   end

   // Counter
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         count_q <= EBTCF_RESET_BYTE;
         down_q <= 1'b0;
      end else if (wr_hit(EBTCF_OFS_COUNT)) begin
         count_q <= wbyte;
      end else if (tick) begin
         if (pc_mode) begin
            if (!down_q && at_top) begin
               down_q <= 1'b1;
               count_q <= count_q - 1'b1;
            end else if (down_q && at_bottom) begin
               down_q <= 1'b0;
               count_q <= count_q + 1'b1;
            end else begin
               count_q <= down_q ? count_q - 1'b1 : count_q + 1'b1;
            end
         end else begin
            down_q <= 1'b0;
            count_q <= (wgm != EBTCF_WGM_NORMAL && at_top) ? EBTCF_BOTTOM : count_q + 1'b1;
         end
      end
   end

   // Counter write masks the match of the following tick
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         block_q <= 1'b0;
      end else if (wr_hit(EBTCF_OFS_COUNT)) begin
         block_q <= 1'b1;
      end else if (tick) begin
         block_q <= 1'b0;
      end
   end

   // Flags: set beats clear
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         flags_q <= 3'h0;
      end else begin
         flags_q <= (flags_q & ~clr_w &
                     ~((wr_hit(EBTCF_OFS_ACK)) ? wbyte[2:0] : 3'h0)) | set_evt;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         irq_q <= 3'h0;
      end else begin
         irq_q <= flags_q & mask_q & {3{i_cpu_status_word_ie}};
      end
   end

   // Waveform outputs
   function automatic logic wave_next(input logic cur, input logic [1:0] act, input logic hit,
                                      input logic force_hit, input logic ch_a);
      logic r;
      r = cur;
      if (!pwm_mode) begin
         if (hit || force_hit) begin
            case (act)
               EBTCF_ACT_TOGGLE: r = ~cur;
               EBTCF_ACT_CLEAR: r = 1'b0;
               EBTCF_ACT_SET: r = 1'b1;
               default: r = cur;
            endcase
         end
      end else if (fast_mode) begin
         if (act == EBTCF_ACT_TOGGLE) begin
            if (ch_a && wgm[2] && hit) begin
               r = ~cur;
            end
         end else if (act[1]) begin
            if (tick && at_top) begin
               r = ~act[0];
            end else if (hit) begin
               r = act[0];
            end
         end
      end else begin
         if (act == EBTCF_ACT_TOGGLE) begin
            if (ch_a && wgm[2] && hit) begin
               r = ~cur;
            end
         end else if (act[1] && hit) begin
            r = down_q ? ~act[0] : act[0];
         end
      end
      wave_next = r;
   endfunction

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         wave_a_q <= 1'b0;
         wave_b_q <= 1'b0;
      end else begin
         wave_a_q <= wave_next(wave_a_q, ctrl_a_q[EBTCF_CA_ACT_A +: 2], match_a, force_a, 1'b1);
         wave_b_q <= wave_next(wave_b_q, ctrl_a_q[EBTCF_CA_ACT_B +: 2], match_b, force_b, 1'b0);
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      case (i_avs_address)
         EBTCF_OFS_CTRL_A: rd_mux = ctrl_a_q;
         EBTCF_OFS_CTRL_B: rd_mux = ctrl_b_q & EBTCF_CB_READ_MASK;
         EBTCF_OFS_COUNT: rd_mux = count_q;
         EBTCF_OFS_CMP_A: rd_mux = cmp_a_q;
         EBTCF_OFS_CMP_B: rd_mux = cmp_b_q;
         EBTCF_OFS_MASK: rd_mux = {5'h00, mask_q};
         EBTCF_OFS_FLAGS: rd_mux = {5'h00, flags_q};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         ack_q <= 1'b0;
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         ack_q <= acc;
         // Registered inverse of ack so the port comes straight from a flop
         wait_q <= !acc;
         if (rd_en) begin
            rdata_q <= {24'h000000, rd_mux};
         end
      end
   end

   assign o_avs_waitrequest = wait_q;
   assign o_avs_readdata = rdata_q;
   assign o_wave_out_a = wave_a_q;
   assign o_wave_out_b = wave_b_q;
   assign o_irq_req = irq_q;
endmodule

// ---- tb/ebtcf_timer_monitor.sv ----
/*
 Checker for the timer block: bus handshake, read-back masks, interrupt gating.
 Assumes it is bound to ebtcf_timer and sees only its ports.
*/
`timescale 1ns/1ps
module ebtcf_timer_monitor (
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   input wire logic [ebtcf_pkg::EBTCF_ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic i_ext_count_pin,
   input wire logic i_cpu_status_word_ie,
   input wire logic o_wave_out_a,
   input wire logic o_wave_out_b,
   input wire logic [2:0] o_irq_req
);
   import ebtcf_pkg::*;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_resetn);
   // A request taken at this edge
   sequence s_take;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence s_rd_at(logic [4:0] a);
      i_avs_read && o_avs_waitrequest && i_avs_address == a;
   endsequence
   sequence s_mask_off;
      s_take ##0 (i_avs_write && i_avs_address == EBTCF_OFS_MASK && i_avs_byteenable[0]
         && i_avs_writedata[2:0] == 3'h0);
   endsequence
   req_gets_ack_a: assert property (s_take |=> !o_avs_waitrequest)
      else $error("request not answered after one wait");
   ack_one_cycle_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   rd_hold_a: assert property (!(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
      else $error("read data changed without a read");
   upper_zero_a: assert property (o_avs_readdata[31:8] == 24'h000000)
      else $error("read data above bit 7 not zero");
   force_rd_zero_a: assert property (s_rd_at(EBTCF_OFS_CTRL_B) |=> o_avs_readdata[7:4] == 4'h0)
      else $error("control B force or reserved bits read nonzero");
   resv_zero_a: assert property ((s_rd_at(EBTCF_OFS_MASK) or s_rd_at(EBTCF_OFS_FLAGS))
      |=> o_avs_readdata[7:3] == 5'h00)
      else $error("mask or flag reserved bits read nonzero");
   irq_gate_a: assert property (!i_cpu_status_word_ie |=> o_irq_req == 3'h0)
      else $error("interrupt request with global enable low");
   mask_off_a: assert property (s_mask_off |=> ##1 o_irq_req == 3'h0)
      else $error("interrupt request after mask cleared");
endmodule

bind ebtcf_timer ebtcf_timer_monitor ebtcf_timer_monitor_i (
   .i_sys_clk, .i_resetn, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
   .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_ext_count_pin,
   .i_cpu_status_word_ie, .o_wave_out_a, .o_wave_out_b, .o_irq_req
);

// ---- tb/ebtcf_timer_bench.sv ----
/*
 Self-checking bench for the timer block: register access, prescaler, external
 count, compare flags, interrupt gating and forced matches.
 Assumes the bench is the only Avalon-MM master of the block.
*/
`timescale 1ns/1ps
module ebtcf_timer_bench;
   import ebtcf_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, ext = 1'b0, ie = 1'b0;
   logic waitreq, wa, wb;
   logic [4:0] adr = 5'h00;
   logic [31:0] wdat = 32'h0, rdat;
   logic [2:0] irq;
   logic [7:0] q;
   int n_errors = 0, check_count = 0;
   int divs[5] = '{1, 8, 64, 256, 1024};

   ebtcf_timer ebtcf_timer_i (.i_sys_clk(clk), .i_resetn(rstn), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'h1),
      .o_avs_readdata(rdat), .o_avs_waitrequest(waitreq), .i_ext_count_pin(ext),
      .i_cpu_status_word_ie(ie), .o_wave_out_a(wa), .o_wave_out_b(wb), .o_irq_req(irq));

   initial begin
      forever #2.5 clk = ~clk;
   end

   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One bus access; called and left just after a rising edge
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      int n;
      n = 0;
      wr <= w;
      rd <= !w;
      adr <= a;
      wdat <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (waitreq && n < 50);
      if (waitreq) begin
         n_errors++;
         $display("mismatch bus wait expected ack seen timeout");
         end_of_test();
      end
      q = rdat[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr8(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdc(input string name, input logic [4:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      check(name, q, exp);
   endtask

   // Run the counter with a clock select for a number of cycles, then stop it
   task automatic run(input logic [2:0] cs, input int cycles);
      wr8(EBTCF_OFS_CTRL_B, {5'h00, cs});
      repeat (cycles) @(posedge clk);
      wr8(EBTCF_OFS_CTRL_B, 8'h00);
   endtask

   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdc("ctrl_b reset", EBTCF_OFS_CTRL_B, 8'h00);
      rdc("count reset", EBTCF_OFS_COUNT, 8'h00);
      rdc("flags reset", EBTCF_OFS_FLAGS, 8'h00);
      wr8(EBTCF_OFS_CTRL_B, 8'hf8);
      rdc("ctrl_b readback", EBTCF_OFS_CTRL_B, 8'h08);
      wr8(EBTCF_OFS_CTRL_B, 8'h00);
      wr8(EBTCF_OFS_MASK, 8'hff);
      rdc("mask readback", EBTCF_OFS_MASK, 8'h07);
      wr8(EBTCF_OFS_COUNT, 8'h5a);
      repeat (20) @(posedge clk);
      rdc("count held", EBTCF_OFS_COUNT, 8'h5a);
      rdc("ack reads zero", EBTCF_OFS_ACK, 8'h00);
      // Each divider for 16 periods: 16 ticks plus edge slack
      for (int cs = 1; cs <= 5; cs++) begin
         wr8(EBTCF_OFS_COUNT, 8'h00);
         run(3'(cs), divs[cs-1] * 16);
         bus(1'b0, EBTCF_OFS_COUNT, 8'h00);
         check("prescale ticks", {7'h0, q >= 8'd15 && q <= 8'd19}, 8'h01);
      end
      for (int e = 6; e <= 7; e++) begin
         wr8(EBTCF_OFS_COUNT, 8'h00);
         wr8(EBTCF_OFS_CTRL_B, 8'(e));
         repeat (5) begin
            ext <= 1'b1;
            repeat (3) @(posedge clk);
            ext <= 1'b0;
            repeat (3) @(posedge clk);
         end
         wr8(EBTCF_OFS_CTRL_B, 8'h00);
         rdc("ext edges", EBTCF_OFS_COUNT, 8'h05);
      end
      wr8(EBTCF_OFS_CMP_A, 8'h10);
      wr8(EBTCF_OFS_CMP_B, 8'h20);
      wr8(EBTCF_OFS_FLAGS, 8'h07);
      wr8(EBTCF_OFS_COUNT, 8'h10);
      run(3'h1, 22);
      rdc("blocked match", EBTCF_OFS_FLAGS, 8'h04);
      wr8(EBTCF_OFS_COUNT, 8'hf0);
      run(3'h1, 40);
      rdc("overflow", EBTCF_OFS_FLAGS, 8'h07);
      check("irq global off", {5'h0, irq}, 8'h00);
      ie <= 1'b1;
      repeat (3) @(posedge clk);
      check("irq on", {5'h0, irq}, 8'h07);
      wr8(EBTCF_OFS_MASK, 8'h02);
      check("irq masked", {5'h0, irq}, 8'h02);
      wr8(EBTCF_OFS_FLAGS, 8'h02);
      wr8(EBTCF_OFS_FLAGS, 8'h00);
      rdc("write one clear", EBTCF_OFS_FLAGS, 8'h05);
      wr8(EBTCF_OFS_ACK, 8'h05);
      rdc("vector clear", EBTCF_OFS_FLAGS, 8'h00);
      check("irq cleared", {5'h0, irq}, 8'h00);
      wr8(EBTCF_OFS_COUNT, 8'h05);
      wr8(EBTCF_OFS_CTRL_A, 8'h72);
      wr8(EBTCF_OFS_CTRL_B, 8'hc0);
      check("force outputs", {6'h0, wa, wb}, 8'h03);
      rdc("force no clear", EBTCF_OFS_COUNT, 8'h05);
      rdc("force no flag", EBTCF_OFS_FLAGS, 8'h00);
      wr8(EBTCF_OFS_CTRL_A, 8'ha3);
      wr8(EBTCF_OFS_CTRL_B, 8'hc0);
      check("pwm ignores force", {6'h0, wa, wb}, 8'h03);
      // Software side keeps the force bits zero while in PWM
      wr8(EBTCF_OFS_CTRL_B, 8'h00);
      check("pwm zero write", {6'h0, wa, wb}, 8'h03);
      wr8(EBTCF_OFS_CTRL_A, 8'ha0);
      wr8(EBTCF_OFS_CTRL_B, 8'hc0);
      check("force clear", {6'h0, wa, wb}, 8'h00);
      // Clear-on-match with top 8: 34 ticks from 0 end at 7, three toggles of A
      wr8(EBTCF_OFS_CMP_A, 8'h08);
      wr8(EBTCF_OFS_CTRL_A, 8'h42);
      wr8(EBTCF_OFS_COUNT, 8'h00);
      run(3'h1, 31);
      rdc("ctc count", EBTCF_OFS_COUNT, 8'h07);
      rdc("ctc flags", EBTCF_OFS_FLAGS, 8'h02);
      check("ctc toggle", {6'h0, wa, wb}, 8'h02);
      end_of_test();
   end
endmodule
